/* File: lxc_ctrl.sv */
// mode, wake, timeout and slope control for two bus transceiver channels
//
// Operation
// - power-up in off mode, no bus activity
// - off mode ignores all bus wake patterns
// - normal mode selectable only in system normal/stop
// - normal mode: low transmit drives bus dominant
// - early low transmit suppressed until released, expired
// - receive output mirrors bus when reception active
// - receive-only: driver off, reception kept, normal/stop
// - wake mode programmable; forced in fail-safe
// - wake: falling edge, long dominant, rising fires
// - dominant 30 to 150 us qualifies wake; code has no upper limit, longer dominant also fires
// - after wake receive stays low until mode change or rearm
// - mode reads wake after wake; rewrite no rearm
// - rearm by mode toggle or stop/sleep/fail-safe
// - wake in normal/stop: interrupt, status, receive low
// - stop-mode wake enables watchdog if option set
// - wake in sleep/restart/fail-safe requests restart, no interrupt
// - transmit dominant timeout holds bus recessive, sets fault
// - bus dominant timeout sets fault, mode unchanged
// - bus undervoltage disables driver and receiver
// - normal slope default; low slope changes slew
// - low slope written in system normal, at select rise
// - flash bit written in system normal disables slope control at select rise
`timescale 1ns/10ps
`default_nettype none
module lxc_ctrl #(
    parameter int P_WAKE_FILT_CYC = lxc_pkg::L_WAKE_FILT_CYC,
    parameter int P_TX_TO_CYC = lxc_pkg::L_TX_TO_CYC,
    parameter int P_BUS_TO_CYC = lxc_pkg::L_BUS_TO_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire lxc_pkg::lxc_sys_t i_sys_mode,
    input wire logic i_wd_enabled,
    input wire logic i_watchdog_on_bus_wake,
    input wire logic i_bus_supply_ok,
    input wire logic i_serial_select_n,
    input wire logic i_cfg_valid,
    input wire lxc_pkg::lxc_cfg_t i_cfg_data,
    output logic o_cfg_ready,
    input wire logic [1:0] i_bus_tx_input,
    input wire logic [1:0] i_bus_level,
    input wire logic [1:0] i_fault_clear,
    input wire logic [1:0] i_wake_clear,
    output logic [1:0] o_bus_drive,
    output logic [1:0] o_bus_rx_out_pin,
    output logic [1:0] o_xcvr_a_mode_field,
    output logic [1:0] o_xcvr_b_mode_field,
    output logic o_xcvr_a_fault_flag,
    output logic o_xcvr_b_fault_flag,
    output logic [1:0] o_wake_source_status,
    output logic o_int_pulse,
    output logic o_restart_req,
    output logic o_wd_enable_req,
    output logic o_low_slope_select,
    output logic o_slope_ctrl_off
);
    localparam int CW = lxc_pkg::L_CNT_W;
    localparam logic [CW-1:0] L_WK_LIM = CW'(P_WAKE_FILT_CYC - 1);
    localparam logic [CW-1:0] L_EN_LIM = CW'(lxc_pkg::L_EN_CYC - 1);
    localparam logic [CW-1:0] L_TX_LIM = CW'(P_TX_TO_CYC);
    localparam logic [CW-1:0] L_BUS_LIM = CW'(P_BUS_TO_CYC);

    typedef struct packed {
        lxc_pkg::lxc_wk_t wk;
        logic [1:0] mode;
        logic woke;
        logic [CW-1:0] wk_cnt;
        logic [CW-1:0] en_cnt;
        logic [CW-1:0] tx_cnt;
        logic [CW-1:0] bus_cnt;
        logic en_done;
        logic tx_blocked;
        logic tx_to;
        logic fault;
        logic wake_stat;
        logic rx;
        logic drive;
    } lxc_chan_t;

    typedef struct packed {
        lxc_chan_t [1:0] ch;
        lxc_pkg::lxc_sys_t sys_prev;
        logic cs_prev;
        logic low_slope;
        logic flash;
        logic int_p;
        logic restart_p;
        logic wd_p;
    } lxc_state_t;

    lxc_state_t s;
    lxc_state_t next_s;
    lxc_chan_t c;
    logic cs_rise;
    logic pop;
    logic sys_chg;
    logic rearm;
    logic fire;
    logic dom;
    logic [1:0] req;

    lxc_cfg_if cfg ();

    lxc_cfg_fifo #(
        .W(lxc_pkg::L_CFG_W),
        .D(lxc_pkg::L_CFG_DEPTH)
    ) u_cfg_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .bus(cfg.store)
    );

    // a word is drained only by a select rise, so a busy writer stalls on o_cfg_ready
    assign cfg.push_valid = i_cfg_valid;
    assign cfg.push_data = i_cfg_data;
    assign o_cfg_ready = cfg.push_ready;
    assign cs_rise = i_serial_select_n & ~s.cs_prev;
    assign cfg.pop_ready = cs_rise;

    function automatic logic rx_active(input logic [1:0] mode);
        rx_active = (mode == lxc_pkg::L_MODE_NORMAL) || (mode == lxc_pkg::L_MODE_RXONLY);
    endfunction

    function automatic logic mode_allowed(input logic [1:0] mode, input lxc_pkg::lxc_sys_t sys);
        logic nrm_stp;
        nrm_stp = (sys == lxc_pkg::LXC_SYS_NORMAL) || (sys == lxc_pkg::LXC_SYS_STOP);
        if (mode == lxc_pkg::L_MODE_OFF) begin
            mode_allowed = 1'b1;
        end else if (mode == lxc_pkg::L_MODE_WAKE) begin
            mode_allowed = nrm_stp || (sys == lxc_pkg::LXC_SYS_SLEEP) || (sys == lxc_pkg::LXC_SYS_RESTART);
        end else begin
            mode_allowed = nrm_stp;
        end
    endfunction

    function automatic lxc_state_t rst_state();
        lxc_state_t r;
        r = '0;
        r.sys_prev = lxc_pkg::LXC_SYS_INIT;
        r.cs_prev = 1'b1;
        for (int k = 0; k < 2; k++) begin
            r.ch[k].mode = lxc_pkg::L_MODE_OFF;
            r.ch[k].wk = lxc_pkg::LXC_WK_WAIT_REC;
            r.ch[k].rx = 1'b1;
        end
        // normal slope after reset
        r.low_slope = 1'b0;
        return r;
    endfunction

    always_comb begin
        next_s = s;
        c = s.ch[0];
        fire = 1'b0;
        dom = 1'b0;
        req = '0;
        next_s.int_p = 1'b0;
        next_s.restart_p = 1'b0;
        next_s.wd_p = 1'b0;
        next_s.cs_prev = i_serial_select_n;
        next_s.sys_prev = i_sys_mode;
        pop = cs_rise & cfg.pop_valid;
        sys_chg = (i_sys_mode != s.sys_prev);
        rearm = sys_chg && ((i_sys_mode == lxc_pkg::LXC_SYS_STOP) || (i_sys_mode == lxc_pkg::LXC_SYS_SLEEP)
                || (i_sys_mode == lxc_pkg::LXC_SYS_FAILSAFE));
        if (pop && i_sys_mode == lxc_pkg::LXC_SYS_NORMAL) begin
            next_s.low_slope = cfg.pop_data.low_slope;
            next_s.flash = cfg.pop_data.flash;
        end
        // each channel keeps its own copy of mode, wake, counter and flag state; slope, flash and pulse state are shared
        for (int i = 0; i < 2; i++) begin
            c = s.ch[i];
            fire = 1'b0;
            dom = ~i_bus_level[i];
            req = (i == 0) ? cfg.pop_data.mode_a : cfg.pop_data.mode_b;
            // rewriting the current value changes nothing, so a woken channel stays woken
            if (pop && req != c.mode && mode_allowed(req, i_sys_mode)) begin
                c.mode = req;
                c.woke = 1'b0;
                c.wk = lxc_pkg::LXC_WK_WAIT_REC;
                c.en_cnt = '0;
                c.en_done = 1'b0;
                c.tx_blocked = 1'b0;
            end
            if (sys_chg && i_sys_mode == lxc_pkg::LXC_SYS_FAILSAFE) begin
                c.mode = lxc_pkg::L_MODE_WAKE;
            end
            if (rearm) begin
                c.woke = 1'b0;
                c.wk = lxc_pkg::LXC_WK_WAIT_REC;
            end
            // enabling time: a low transmit input seen early stays blocked until it releases
            if (c.mode == lxc_pkg::L_MODE_NORMAL && !c.en_done) begin
                if (c.en_cnt == L_EN_LIM) begin
                    c.en_done = 1'b1;
                end else begin
                    c.en_cnt = CW'(c.en_cnt + 1'b1);
                end
                if (!i_bus_tx_input[i]) begin
                    c.tx_blocked = 1'b1;
                end
            end else if (c.en_done && i_bus_tx_input[i]) begin
                c.tx_blocked = 1'b0;
            end
            // transmit dominant timeout, released when the input goes high
            if (c.mode == lxc_pkg::L_MODE_NORMAL && !i_bus_tx_input[i]) begin
                if (c.tx_cnt >= L_TX_LIM) begin
                    c.tx_to = 1'b1;
                end else begin
                    c.tx_cnt = CW'(c.tx_cnt + 1'b1);
                end
            end else begin
                c.tx_cnt = '0;
                c.tx_to = 1'b0;
            end
            // bus clamp detection leaves the mode as it is
            if (rx_active(c.mode) && i_bus_supply_ok && dom) begin
                if (c.bus_cnt < L_BUS_LIM) begin
                    c.bus_cnt = CW'(c.bus_cnt + 1'b1);
                end
            end else begin
                c.bus_cnt = '0;
            end
            // wake detector runs only while armed in wake mode; off mode never gets here
            if (c.mode == lxc_pkg::L_MODE_WAKE && !c.woke && i_bus_supply_ok) begin
                unique case (c.wk)
                    lxc_pkg::LXC_WK_WAIT_REC: begin
                        if (!dom) begin
                            c.wk = lxc_pkg::LXC_WK_WAIT_DOM;
                        end
                    end
                    lxc_pkg::LXC_WK_WAIT_DOM: begin
                        if (dom) begin
                            c.wk = lxc_pkg::LXC_WK_FILTER;
                            c.wk_cnt = '0;
                        end
                    end
                    lxc_pkg::LXC_WK_FILTER: begin
                        if (!dom) begin
                            c.wk = lxc_pkg::LXC_WK_WAIT_DOM;
                        end else if (c.wk_cnt == L_WK_LIM) begin
                            c.wk = lxc_pkg::LXC_WK_QUAL;
                        end else begin
                            c.wk_cnt = CW'(c.wk_cnt + 1'b1);
                        end
                    end
                    lxc_pkg::LXC_WK_QUAL: begin
                        if (!dom) begin
                            fire = 1'b1;
                            c.woke = 1'b1;
                            c.wk = lxc_pkg::LXC_WK_WAIT_REC;
                        end
                    end
                endcase
            end else if (c.mode != lxc_pkg::L_MODE_WAKE) begin
                c.wk = lxc_pkg::LXC_WK_WAIT_REC;
            end
            if (fire) begin
                if (i_sys_mode == lxc_pkg::LXC_SYS_NORMAL || i_sys_mode == lxc_pkg::LXC_SYS_STOP) begin
                    next_s.int_p = 1'b1;
                    if (i_sys_mode == lxc_pkg::LXC_SYS_STOP && !i_wd_enabled && i_watchdog_on_bus_wake) begin
                        next_s.wd_p = 1'b1;
                    end
                end else if (i_sys_mode == lxc_pkg::LXC_SYS_SLEEP || i_sys_mode == lxc_pkg::LXC_SYS_RESTART
                        || i_sys_mode == lxc_pkg::LXC_SYS_FAILSAFE) begin
                    next_s.restart_p = 1'b1;
                end
            end
            // sticky flags: a new event in the clearing cycle wins
            c.fault = (c.fault & ~i_fault_clear[i]) | c.tx_to | (c.bus_cnt == L_BUS_LIM);
            c.wake_stat = (c.wake_stat & ~i_wake_clear[i]) | fire;
            // undervoltage suspends both stages without touching the mode
            c.drive = i_bus_supply_ok && c.mode == lxc_pkg::L_MODE_NORMAL && c.en_done && !c.tx_blocked
                    && !c.tx_to && !i_bus_tx_input[i];
            if (!i_bus_supply_ok) begin
                c.rx = 1'b1;
            end else if (rx_active(c.mode)) begin
                c.rx = i_bus_level[i];
            end else if (c.mode == lxc_pkg::L_MODE_WAKE && c.woke) begin
                c.rx = 1'b0;
            end else begin
                c.rx = 1'b1;
            end
            next_s.ch[i] = c;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            s <= rst_state();
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    generate
        for (genvar g = 0; g < 2; g++) begin : g_ch
            assign o_bus_drive[g] = s.ch[g].drive;
            assign o_bus_rx_out_pin[g] = s.ch[g].rx;
            assign o_wake_source_status[g] = s.ch[g].wake_stat;
        end
    endgenerate

    assign o_xcvr_a_mode_field = s.ch[0].mode;
    assign o_xcvr_b_mode_field = s.ch[1].mode;
    assign o_xcvr_a_fault_flag = s.ch[0].fault;
    assign o_xcvr_b_fault_flag = s.ch[1].fault;
    assign o_int_pulse = s.int_p;
    assign o_restart_req = s.restart_p;
    assign o_wd_enable_req = s.wd_p;
    // slope selection only reshapes the analog slew; flash bypass wins over low slope
    assign o_low_slope_select = s.low_slope & ~s.flash;
    assign o_slope_ctrl_off = s.flash;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_qual_release;
        i_ce && s.ch[0].wk == lxc_pkg::LXC_WK_QUAL && s.ch[0].mode == lxc_pkg::L_MODE_WAKE && !s.ch[0].woke
        && i_bus_level[0] && i_bus_supply_ok && !sys_chg && !cs_rise;
    endsequence

    sequence s_woken;
        s.ch[0].woke && s.ch[0].wake_stat && !o_bus_rx_out_pin[0];
    endsequence

    a_wake_fire_seq:
    assert property (s_qual_release |=> s_woken)
        else $error("qualified wake release did not wake channel a");

    a_wake_filter_len:
    assert property (s.ch[0].wk == lxc_pkg::LXC_WK_QUAL |-> s.ch[0].wk_cnt == L_WK_LIM)
        else $error("wake qualified before filter time");

    a_off_no_wake:
    assert property ($rose(s.ch[0].wake_stat) |-> $past(s.ch[0].mode) == lxc_pkg::L_MODE_WAKE)
        else $error("wake reported outside wake mode");

    a_drive_follows_tx:
    assert property (i_ce && i_bus_supply_ok && s.ch[0].mode == lxc_pkg::L_MODE_NORMAL && s.ch[0].en_done
        && !s.ch[0].tx_blocked && !s.ch[0].tx_to && s.ch[0].tx_cnt < L_TX_LIM
        && !i_bus_tx_input[0] && !sys_chg && !cs_rise |=> o_bus_drive[0])
        else $error("channel a did not drive dominant");

    a_enable_blocks_tx:
    assert property (i_ce && s.ch[0].mode == lxc_pkg::L_MODE_NORMAL && !s.ch[0].en_done && !i_bus_tx_input[0]
        |=> !o_bus_drive[0] [*2])
        else $error("transmit passed during enabling time");

    a_rx_mirror:
    assert property (i_ce && i_bus_supply_ok && rx_active(s.ch[0].mode) && !sys_chg && !cs_rise
        |=> o_bus_rx_out_pin[0] == $past(i_bus_level[0]))
        else $error("receive output does not follow bus");

    a_rxonly_no_drive:
    assert property (s.ch[0].mode == lxc_pkg::L_MODE_RXONLY |-> !o_bus_drive[0])
        else $error("driver active in receive-only mode");

    a_wake_int_normal:
    assert property ($rose(s.ch[0].wake_stat) && ($past(i_sys_mode) == lxc_pkg::LXC_SYS_NORMAL
        || $past(i_sys_mode) == lxc_pkg::LXC_SYS_STOP) |-> o_int_pulse)
        else $error("no interrupt on wake in normal or stop mode");

    a_sleep_restart:
    assert property ($rose(s.ch[0].wake_stat) && $past(i_sys_mode) == lxc_pkg::LXC_SYS_SLEEP
        |-> o_restart_req && !o_int_pulse)
        else $error("sleep wake handled wrongly");

    a_fault_sticky:
    assert property ($fell(s.ch[0].fault) |-> $past(i_fault_clear[0]))
        else $error("fault flag dropped without clear");

    a_undervolt_off:
    assert property (i_ce && !i_bus_supply_ok |=> !o_bus_drive[0] && !o_bus_drive[1] && o_bus_rx_out_pin[0])
        else $error("stages active under undervoltage");
endmodule
`default_nettype wire

/* File: lxc_pkg.sv */
// constants, types and timing for the two-channel bus transceiver control
package lxc_pkg;
    // clock and counter width
    localparam int L_CLK_PERIOD_NS = 4;
    localparam int L_CNT_W = 24;
    // transceiver mode field encodings
    localparam logic [1:0] L_MODE_OFF = 2'h0;
    localparam logic [1:0] L_MODE_WAKE = 2'h1;
    localparam logic [1:0] L_MODE_RXONLY = 2'h2;
    localparam logic [1:0] L_MODE_NORMAL = 2'h3;
    // wake filter window in microseconds, least and longest
    localparam int L_WAKE_FILT_MIN_US = 30;
    localparam int L_WAKE_FILT_MAX_US = 150;
    localparam int L_WAKE_FILT_CYC = (L_WAKE_FILT_MIN_US * 1000 + L_CLK_PERIOD_NS - 1) / L_CLK_PERIOD_NS;
    localparam int L_WAKE_FILT_MAX_CYC = (L_WAKE_FILT_MAX_US * 1000) / L_CLK_PERIOD_NS;
    // enabling time after entering normal mode
    localparam int L_EN_TIME_US = 10;
    localparam int L_EN_CYC = (L_EN_TIME_US * 1000 + L_CLK_PERIOD_NS - 1) / L_CLK_PERIOD_NS;
    // dominant timeouts for transmit input and bus
    localparam int L_TX_TO_US = 2000;
    localparam int L_TX_TO_CYC = (L_TX_TO_US * 1000 + L_CLK_PERIOD_NS - 1) / L_CLK_PERIOD_NS;
    localparam int L_BUS_TO_US = 2000;
    localparam int L_BUS_TO_CYC = (L_BUS_TO_US * 1000 + L_CLK_PERIOD_NS - 1) / L_CLK_PERIOD_NS;
    // configuration buffer depth
    localparam int L_CFG_DEPTH = 2;

    typedef enum logic [2:0] {
        LXC_SYS_INIT,
        LXC_SYS_NORMAL,
        LXC_SYS_STOP,
        LXC_SYS_SLEEP,
        LXC_SYS_RESTART,
        LXC_SYS_FAILSAFE
    } lxc_sys_t;

    typedef enum logic [1:0] {
        LXC_WK_WAIT_REC,
        LXC_WK_WAIT_DOM,
        LXC_WK_FILTER,
        LXC_WK_QUAL
    } lxc_wk_t;

    typedef struct packed {
        logic [1:0] mode_a;
        logic [1:0] mode_b;
        logic low_slope;
        logic flash;
    } lxc_cfg_t;

    localparam int L_CFG_W = $bits(lxc_cfg_t);
endpackage

/* File: lxc_cfg_if.sv */
// carrier between the control block and its configuration buffer
`timescale 1ns/10ps
`default_nettype none
interface lxc_cfg_if;
    logic push_valid;
    logic push_ready;
    lxc_pkg::lxc_cfg_t push_data;
    logic pop_valid;
    logic pop_ready;
    lxc_pkg::lxc_cfg_t pop_data;
    modport user (output push_valid, output push_data, output pop_ready,
                  input push_ready, input pop_valid, input pop_data);
    modport store (input push_valid, input push_data, input pop_ready,
                   output push_ready, output pop_valid, output pop_data);
endinterface
`default_nettype wire

/* File: lxc_cfg_fifo.sv */
// small flop-based buffer holding configuration words until chip select ends
`timescale 1ns/10ps
`default_nettype none
module lxc_cfg_fifo #(
    parameter int W = lxc_pkg::L_CFG_W,
    parameter int D = lxc_pkg::L_CFG_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    lxc_cfg_if.store bus
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] L_FULL = CW'(D);
    localparam logic [PW-1:0] L_LAST = PW'(D - 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } lxc_fifo_s_t;

    lxc_fifo_s_t s;
    lxc_fifo_s_t next_s;
    logic push;
    logic pop;

    assign bus.push_ready = (s.cnt != L_FULL);
    assign bus.pop_valid = (s.cnt != '0);
    assign bus.pop_data = s.mem[s.rd];

    always_comb begin
        next_s = s;
        push = bus.push_valid & bus.push_ready;
        pop = bus.pop_valid & bus.pop_ready;
        if (push) begin
            next_s.mem[s.wr] = bus.push_data;
            next_s.wr = (s.wr == L_LAST) ? '0 : PW'(s.wr + 1'b1);
        end
        if (pop) begin
            next_s.rd = (s.rd == L_LAST) ? '0 : PW'(s.rd + 1'b1);
        end
        // simultaneous push and pop leaves the fill level unchanged
        if (push && !pop) begin
            next_s.cnt = CW'(s.cnt + 1'b1);
        end else if (pop && !push) begin
            next_s.cnt = CW'(s.cnt - 1'b1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            s <= '0;
        end else if (i_ce) begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

/* File: lxc_mcu_model.sv */
// controller-side model: transmit drivers and pulled-up bus wires
`timescale 1ns/10ps
`default_nettype none
module lxc_mcu_model (
    input wire logic i_ref_clk,
    input wire logic [1:0] i_send,
    input wire logic [1:0] i_early,
    input wire logic [1:0] i_ext_dom,
    input wire logic [1:0] i_bus_drive,
    input wire logic [1:0] i_normal,
    output logic [1:0] o_tx,
    output logic [1:0] o_bus_level
);
    logic [1:0] tx = 2'h3;
    int en_cnt [2] = '{0, 0};
    assign o_tx = tx;
    // pull-up: recessive unless a node drives dominant
    assign o_bus_level = ~(i_bus_drive | i_ext_dom);
    always @(posedge i_ref_clk) begin
        for (int c = 0; c < 2; c++) begin
            en_cnt[c] <= !i_normal[c] ? 0 : (en_cnt[c] < lxc_pkg::L_EN_CYC) ? en_cnt[c] + 1 : en_cnt[c];
            // stays recessive until enabled, unless told to misbehave
            tx[c] <= ~(i_send[c] & ((en_cnt[c] >= lxc_pkg::L_EN_CYC) | i_early[c]));
        end
    end
endmodule
`default_nettype wire

/* File: lin_transceiver_mode_wake_control_bench.sv */
// self-checking bench for the two-channel transceiver control
`timescale 1ns/10ps
`default_nettype none
module lin_transceiver_mode_wake_control_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    lxc_pkg::lxc_sys_t sys = lxc_pkg::LXC_SYS_INIT;
    logic cfg_valid = 1'b0;
    lxc_pkg::lxc_cfg_t cfg_data = '0;
    logic sel_n = 1'b1;
    logic [1:0] send = 2'h0, early = 2'h0, ext_dom = 2'h0, fclr = 2'h0, wclr = 2'h0;
    logic ce = 1'b1, sup_ok = 1'b1;
    logic [1:0] tx, lvl, drive, rx, ma, mb, wst;
    logic cfg_ready, fa, fb, intp, rst_req, wd_req, lsel, soff;
    int err_total = 0, n_checks = 0, cyc_cnt = 0;
    always #2 clk = ~clk;
    lxc_ctrl #(.P_WAKE_FILT_CYC(8), .P_TX_TO_CYC(20), .P_BUS_TO_CYC(40)) lxc_ctrl_inst (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_sys_mode(sys), .i_wd_enabled(1'b0),
        .i_watchdog_on_bus_wake(1'b1), .i_bus_supply_ok(sup_ok), .i_serial_select_n(sel_n),
        .i_cfg_valid(cfg_valid), .i_cfg_data(cfg_data), .o_cfg_ready(cfg_ready), .i_bus_tx_input(tx),
        .i_bus_level(lvl), .i_fault_clear(fclr), .i_wake_clear(wclr), .o_bus_drive(drive),
        .o_bus_rx_out_pin(rx), .o_xcvr_a_mode_field(ma), .o_xcvr_b_mode_field(mb),
        .o_xcvr_a_fault_flag(fa), .o_xcvr_b_fault_flag(fb), .o_wake_source_status(wst),
        .o_int_pulse(intp), .o_restart_req(rst_req), .o_wd_enable_req(wd_req),
        .o_low_slope_select(lsel), .o_slope_ctrl_off(soff));
    lxc_mcu_model lxc_mcu_model_inst (.i_ref_clk(clk), .i_send(send), .i_early(early),
        .i_ext_dom(ext_dom), .i_bus_drive(drive), .o_tx(tx), .o_bus_level(lvl),
        .i_normal({mb == lxc_pkg::L_MODE_NORMAL, ma == lxc_pkg::L_MODE_NORMAL}));
    task automatic tally_and_finish;
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        n_checks++;
        if (c !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // push one word, then a select low-high pulse applies it
    task automatic wr(input logic [1:0] a, input logic [1:0] b, input logic ls, input logic fl);
        @(posedge clk);
        cfg_valid <= 1'b1;
        cfg_data <= lxc_pkg::lxc_cfg_t'{a, b, ls, fl};
        @(posedge clk);
        cfg_valid <= 1'b0;
        sel_n <= 1'b0;
        @(posedge clk);
        sel_n <= 1'b1;
        cyc(1);
    endtask
    // dominant for n cycles, back to recessive, sampled one edge later
    task automatic pat(input logic [1:0] m, input int n);
        @(posedge clk);
        ext_dom <= m;
        repeat (n) @(posedge clk);
        ext_dom <= 2'h0;
        cyc(1);
    endtask
    task automatic t_reset;
        chk(ma === lxc_pkg::L_MODE_OFF && mb === lxc_pkg::L_MODE_OFF, "not off");
        chk(rx === 2'h3 && drive === 2'h0, "bus active");
        chk(lsel === 1'b0 && soff === 1'b0, "slope default");
    endtask
    task automatic t_modes;
        wr(lxc_pkg::L_MODE_NORMAL, lxc_pkg::L_MODE_NORMAL, 1'b1, 1'b0);
        chk(ma === lxc_pkg::L_MODE_OFF && lsel === 1'b0, "init accepted");
        sys <= lxc_pkg::LXC_SYS_NORMAL;
        wr(lxc_pkg::L_MODE_NORMAL, lxc_pkg::L_MODE_RXONLY, 1'b1, 1'b0);
        chk(ma === lxc_pkg::L_MODE_NORMAL && mb === lxc_pkg::L_MODE_RXONLY, "modes");
        chk(lsel === 1'b1, "low slope");
        wr(lxc_pkg::L_MODE_NORMAL, lxc_pkg::L_MODE_RXONLY, 1'b1, 1'b1);
        chk(soff === 1'b1 && lsel === 1'b0, "flash");
    endtask
    task automatic t_enable;
        early <= 2'h1;
        send <= 2'h1;
        cyc(10);
        chk(drive[0] === 1'b0, "early bit sent");
        send <= 2'h0;
        cyc(2500);
        early <= 2'h0;
        send <= 2'h1;
        ext_dom <= 2'h2;
        cyc(4);
        chk(drive === 2'h1 && rx === 2'h0, "tx or rx path");
        send <= 2'h0;
        cyc(4);
        chk(drive[0] === 1'b0 && rx[0] === 1'b1, "recessive");
        ext_dom <= 2'h0;
    endtask
    task automatic t_faults;
        send <= 2'h1;
        cyc(30);
        chk(drive[0] === 1'b0 && fa === 1'b1 && ma === lxc_pkg::L_MODE_NORMAL, "tx timeout");
        chk(fb === 1'b0, "fault leaked");
        send <= 2'h0;
        cyc(4);
        send <= 2'h1;
        cyc(4);
        chk(drive[0] === 1'b1 && fa === 1'b1, "re-enable or sticky");
        send <= 2'h0;
        fclr <= 2'h1;
        cyc(2);
        fclr <= 2'h0;
        chk(fa === 1'b0, "clear");
        pat(2'h2, 50);
        chk(fb === 1'b1 && mb === lxc_pkg::L_MODE_RXONLY, "clamp");
    endtask
    // supply drop must leave the mode alone, and a frozen clock enable must keep the driver from moving
    task automatic t_supply;
        send <= 2'h1;
        sup_ok <= 1'b0;
        cyc(4);
        chk(drive === 2'h0 && rx === 2'h3 && ma === lxc_pkg::L_MODE_NORMAL, "undervoltage");
        sup_ok <= 1'b1;
        cyc(3);
        chk(drive[0] === 1'b1, "supply recovery");
        send <= 2'h0;
        cyc(3);
        ce <= 1'b0;
        send <= 2'h1;
        cyc(4);
        chk(drive[0] === 1'b0, "state moved with enable low");
        ce <= 1'b1;
        cyc(3);
        chk(drive[0] === 1'b1, "no drive after enable");
        send <= 2'h0;
        cyc(3);
    endtask
    task automatic t_wake;
        sys <= lxc_pkg::LXC_SYS_STOP;
        wr(lxc_pkg::L_MODE_WAKE, lxc_pkg::L_MODE_OFF, 1'b0, 1'b0);
        pat(2'h3, 4);
        chk(intp === 1'b0, "short wake");
        pat(2'h3, 12);
        chk(intp === 1'b1 && rst_req === 1'b0 && wd_req === 1'b1, "stop wake");
        chk(wst === 2'h1 && rx === 2'h2 && ma === lxc_pkg::L_MODE_WAKE, "wake state");
        wr(lxc_pkg::L_MODE_WAKE, lxc_pkg::L_MODE_OFF, 1'b0, 1'b0);
        pat(2'h1, 12);
        chk(intp === 1'b0 && rx[0] === 1'b0, "rearmed by rewrite");
        sys <= lxc_pkg::LXC_SYS_SLEEP;
        wclr <= 2'h3;
        cyc(2);
        wclr <= 2'h0;
        chk(wst === 2'h0 && rx[0] === 1'b1, "wake clear or rearm");
        pat(2'h1, 12);
        chk(rst_req === 1'b1 && intp === 1'b0 && wst === 2'h1, "sleep wake");
        wr(lxc_pkg::L_MODE_OFF, lxc_pkg::L_MODE_OFF, 1'b0, 1'b0);
        chk(rx[0] === 1'b1, "rx held");
        sys <= lxc_pkg::LXC_SYS_FAILSAFE;
        cyc(2);
        chk(ma === lxc_pkg::L_MODE_WAKE && mb === lxc_pkg::L_MODE_WAKE, "fail-safe");
        cfg_valid <= 1'b1;
        cyc(3);
        cfg_valid <= 1'b0;
        chk(cfg_ready === 1'b0 && ma === lxc_pkg::L_MODE_WAKE, "buffer not full or applied early");
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 10000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        cyc(16);
        rst_b <= 1'b1;
        cyc(1);
        t_reset();
        t_modes();
        t_enable();
        t_faults();
        t_supply();
        t_wake();
        tally_and_finish();
    end
endmodule
`default_nettype wire
